// *** pkg/fns_pkg.sv ***
// Shared constants and types for the synthesizer control logic
package fns_pkg;

    // Serial word and register selection
    localparam int WORD_W = 24;
    localparam logic [1:0] SEL_FEEDBACK = 2'h0;
    localparam logic [1:0] SEL_REFERENCE = 2'h1;
    localparam logic [1:0] SEL_CONTROL = 2'h2;
    localparam logic [1:0] SEL_NOISE_SPUR = 2'h3;

    // Feedback divider word fields
    localparam int FB_FAST_BIT = 23;
    localparam int FB_INT_LSB = 14;
    localparam int FB_INT_W = 9;
    localparam int FB_FRACTION_NUMERATOR_LSB = 2;
    localparam int FRACTION_NUMERATOR_W = 12;

    // Reference divider word fields
    localparam int RD_LOAD_BIT = 23;
    localparam int RD_MON_LSB = 20;
    localparam int MON_W = 3;
    localparam int RD_PRESCALER_BIT = 18;
    localparam int RD_RDIV_LSB = 14;
    localparam int RDIV_W = 4;
    localparam int RD_MOD_LSB = 2;

    // Control word fields
    localparam int CT_CNT_RST_BIT = 2;
    localparam int CT_CP_TRI_BIT = 3;
    localparam int CT_PWR_DOWN_BIT = 4;
    localparam int CT_PRECISION_BIT = 5;
    localparam int CT_POLARITY_BIT = 6;
    localparam int CT_CP_CUR_LSB = 7;
    localparam int CP_CUR_W = 4;
    localparam int CT_DOUBLER_BIT = 11;

    // Noise and spur word field
    localparam int NS_MODE_LSB = 2;

    // Reset values
    localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
    localparam logic [FRACTION_NUMERATOR_W-1:0] MOD_RESET = 12'h000;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOCK_WIN_NS = 15;
    localparam int UNLOCK_NS = 30;
    localparam int LOCK_WIN_CYC = (LOCK_WIN_NS / CLK_PERIOD_NS < 1) ? 1 :
        LOCK_WIN_NS / CLK_PERIOD_NS;
    localparam int UNLOCK_CYC = (UNLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_COUNT_LOW = 24;
    localparam int LOCK_COUNT_HIGH = 40;
    localparam int FAST_CP_MULT = 16;

    typedef enum logic [2:0] {
        MON_TRISTATE,
        MON_DIGITAL_LOCK,
        MON_FEEDBACK_DIV,
        MON_LOGIC_HIGH,
        MON_REFERENCE_DIV,
        MON_ANALOG_LOCK,
        MON_FAST_SWITCH,
        MON_LOGIC_LOW
    } fns_mon_e;

    typedef enum logic [1:0] {
        NS_LOWEST_SPUR,
        NS_LOW_NOISE_SPUR,
        NS_RESERVED,
        NS_LOWEST_NOISE
    } fns_noise_e;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic valid;
    } fns_word_s;

    typedef struct packed {
        logic [FB_INT_W-1:0] int_value;
        logic [FRACTION_NUMERATOR_W-1:0] fraction_numerator;
        logic [FRACTION_NUMERATOR_W-1:0] fraction_modulus;
        logic [RDIV_W-1:0] ref_div;
        logic prescaler_89;
        logic pd_polarity;
    } fns_div_s;

endpackage : fns_pkg

// *** verilog/fns_serial_rx.sv ***
// Three-wire serial word receiver
`timescale 1ns/1ps
`default_nettype none
module fns_serial_rx
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_load,
    output fns_pkg::fns_word_s word
);

    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic clk_prev_reg;
    logic load_prev_reg;
    logic [fns_pkg::WORD_W-1:0] shift_reg;
    fns_pkg::fns_word_s word_reg;
    wire clk_rise;
    wire load_rise;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            clk_prev_reg <= 1'b0;
            load_prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            sync1_reg <= {ser_load, ser_data, ser_clk};
            sync2_reg <= sync1_reg;
            clk_prev_reg <= sync2_reg[0];
            load_prev_reg <= sync2_reg[2];
        end
    end

    assign clk_rise = sync2_reg[0] & ~clk_prev_reg;
    assign load_rise = sync2_reg[2] & ~load_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Shift in MSB first, latch on load strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            shift_reg <= fns_pkg::WORD_RESET;
            word_reg <= '0;
        end
        else if (clk_en)
        begin
            if (clk_rise)
                shift_reg <= {shift_reg[fns_pkg::WORD_W-2:0], sync2_reg[1]};
            word_reg.valid <= load_rise;
            if (load_rise)
                word_reg.data <= shift_reg;
        end
    end

    assign word = word_reg;

endmodule : fns_serial_rx
`default_nettype wire

// *** verilog/fns_lock_detect.sv ***
// Digital lock detector on PFD phase error
`timescale 1ns/1ps
`default_nettype none
module fns_lock_detect
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic precise,
    input wire logic ref_tick,
    input wire logic fb_tick,
    output logic locked
);

    logic run_reg;
    logic [7:0] err_reg;
    logic [5:0] good_reg;
    logic locked_reg;
    wire both;
    wire one;
    wire done;
    wire start;
    wire [7:0] err_val;
    wire good;
    wire bad;
    wire [5:0] target;
    wire [5:0] good_next;

    ////////////////////////////////////////////////////////////////////////
    // Phase error measurement between the two edges
    assign both = ref_tick & fb_tick;
    assign one = ref_tick ^ fb_tick;
    assign done = both | (run_reg & one);
    assign start = one & ~run_reg;
    assign err_val = both ? 8'h00 : ((err_reg == 8'hff) ? 8'hff : err_reg + 8'h01);
    assign good = done & (err_val <= 8'(fns_pkg::LOCK_WIN_CYC));
    assign bad = (done | run_reg) & (err_val > 8'(fns_pkg::UNLOCK_CYC));
    assign target = precise ? 6'(fns_pkg::LOCK_COUNT_HIGH) :
        6'(fns_pkg::LOCK_COUNT_LOW);
    assign good_next = (good_reg >= target) ? target : good_reg + 6'h01;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            run_reg <= 1'b0;
            err_reg <= 8'h00;
            good_reg <= 6'h00;
            locked_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (clear)
            begin
                run_reg <= 1'b0;
                err_reg <= 8'h00;
                good_reg <= 6'h00;
                locked_reg <= 1'b0;
            end
            else
            begin
                run_reg <= start | (run_reg & ~done);
                err_reg <= (run_reg & ~done) ? err_val : 8'h00;
                if (done)
                    good_reg <= good ? good_next : 6'h00;
                if (bad)
                    locked_reg <= 1'b0;
                else if (good && good_next >= target)
                    locked_reg <= 1'b1;
            end
        end
    end

    assign locked = locked_reg;

endmodule : fns_lock_detect
`default_nettype wire

// *** verilog/fns_control_regs.sv ***
// Register bank and control logic of the fractional-N synthesizer
// Operation
// - Nine-bit integer field sets feedback integer
// - Fast lock: 16x current until timer expires
// - Select bits 01 store reference divider word
// - Load bit high loads fast-lock timer
// - Monitor output follows three-bit select field
// - Lock after enough in-window PFD cycles
// - Lock holds until new channel or error
// - Precision bit picks 24 or 40 cycles
// - Reference divided by four-bit ratio 1..15
// - Twelve-bit field is modulus or timer
// - New modulus applies after feedback word write
// - Counter reset bit holds counters in reset
// - Three-state bit floats the charge pump
// - Power-down bit, registers kept intact
// - Power-down resets counters, pump, lock detect
// - Four-bit field sets charge pump current
// - Doubler bit selects one or both edges
// - Select bits 11 store noise/spur word
// - Noise mode sets dither and pump region
// - Select bits 00 store feedback divider word
`timescale 1ns/1ps
`default_nettype none
module fns_control_regs
#(
    parameter int TIMER_W = 12
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_load,
    input wire logic reference_input,
    input wire logic fb_div_in,
    output fns_pkg::fns_div_s div_cfg,
    output logic [fns_pkg::CP_CUR_W-1:0] cp_current,
    output logic cp_fast,
    output logic cp_three_state,
    output logic cp_low_noise,
    output logic dither_en,
    output logic counters_reset,
    output logic power_down,
    output logic ref_tick,
    output logic lock_detect,
    output logic mon_out,
    output logic mon_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    fns_pkg::fns_word_s word;
    logic [fns_pkg::WORD_W-1:0] fb_word_reg;
    logic [fns_pkg::WORD_W-1:0] rd_word_reg;
    logic [fns_pkg::WORD_W-1:0] ct_word_reg;
    logic [fns_pkg::WORD_W-1:0] ns_word_reg;
    logic [fns_pkg::FRACTION_NUMERATOR_W-1:0] mod_pending_reg;
    logic [fns_pkg::FRACTION_NUMERATOR_W-1:0] mod_active_reg;
    logic [TIMER_W-1:0] timer_load_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic [1:0] ref_sync_reg;
    logic [1:0] fb_sync_reg;
    logic ref_prev_reg;
    logic fb_prev_reg;
    logic [fns_pkg::RDIV_W-1:0] rcnt_reg;
    logic ref_tick_reg;
    logic mon_out_reg;
    logic mon_oe_reg;
    logic locked;
    wire [1:0] sel;
    wire wr_fb;
    wire wr_rd;
    wire wr_ct;
    wire wr_ns;
    wire load_timer;
    wire [fns_pkg::FRACTION_NUMERATOR_W-1:0] wr_field;
    wire cnt_rst_bit;
    wire cp_tri_bit;
    wire pd_bit;
    wire precision_bit;
    wire doubler_bit;
    wire hold_counters;
    wire ref_rise;
    wire ref_fall;
    wire ref_edge;
    wire fb_tick;
    wire [fns_pkg::RDIV_W-1:0] r_ratio;
    wire r_wrap;
    wire fast_active;
    wire lock_clear;
    wire [fns_pkg::MON_W-1:0] mon_sel;
    fns_pkg::fns_noise_e ns_mode;
    logic mon_level;
    logic mon_drive;

    ////////////////////////////////////////////////////////////////////////
    // Serial input register, active also in power-down
    fns_serial_rx u_serial_rx
    (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_load(ser_load),
        .word(word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Word decode by the two select bits
    assign sel = word.data[1:0];
    assign wr_fb = word.valid && sel == fns_pkg::SEL_FEEDBACK;
    assign wr_rd = word.valid && sel == fns_pkg::SEL_REFERENCE;
    assign wr_ct = word.valid && sel == fns_pkg::SEL_CONTROL;
    assign wr_ns = word.valid && sel == fns_pkg::SEL_NOISE_SPUR;
    assign load_timer = word.data[fns_pkg::RD_LOAD_BIT];
    assign wr_field = word.data[fns_pkg::RD_MOD_LSB +: fns_pkg::FRACTION_NUMERATOR_W];

    ////////////////////////////////////////////////////////////////////////
    // Write-only word storage
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fb_word_reg <= fns_pkg::WORD_RESET;
            rd_word_reg <= fns_pkg::WORD_RESET;
            ct_word_reg <= fns_pkg::WORD_RESET;
            ns_word_reg <= fns_pkg::WORD_RESET;
        end
        else if (clk_en)
        begin
            if (wr_fb)
                fb_word_reg <= word.data;
            if (wr_rd && !load_timer)
                rd_word_reg <= word.data;
            if (wr_ct)
                ct_word_reg <= word.data;
            if (wr_ns)
                ns_word_reg <= word.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Double-buffered modulus and timer load
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mod_pending_reg <= fns_pkg::MOD_RESET;
            mod_active_reg <= fns_pkg::MOD_RESET;
            timer_load_reg <= '0;
        end
        else if (clk_en)
        begin
            if (wr_rd && load_timer)
                timer_load_reg <= TIMER_W'(wr_field);
            if (wr_rd && !load_timer)
                mod_pending_reg <= wr_field;
            if (wr_fb)
                mod_active_reg <= mod_pending_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control word fields
    assign cnt_rst_bit = ct_word_reg[fns_pkg::CT_CNT_RST_BIT];
    assign cp_tri_bit = ct_word_reg[fns_pkg::CT_CP_TRI_BIT];
    assign pd_bit = ct_word_reg[fns_pkg::CT_PWR_DOWN_BIT];
    assign precision_bit = ct_word_reg[fns_pkg::CT_PRECISION_BIT];
    assign doubler_bit = ct_word_reg[fns_pkg::CT_DOUBLER_BIT];
    assign hold_counters = cnt_rst_bit | pd_bit;

    assign power_down = pd_bit;
    assign counters_reset = hold_counters;
    assign cp_three_state = cp_tri_bit | pd_bit;
    assign cp_current = ct_word_reg[fns_pkg::CT_CP_CUR_LSB +: fns_pkg::CP_CUR_W];

    assign div_cfg.int_value = fb_word_reg[fns_pkg::FB_INT_LSB +: fns_pkg::FB_INT_W];
    assign div_cfg.fraction_numerator = fb_word_reg[fns_pkg::FB_FRACTION_NUMERATOR_LSB +: fns_pkg::FRACTION_NUMERATOR_W];
    assign div_cfg.fraction_modulus = mod_active_reg;
    assign div_cfg.ref_div = rd_word_reg[fns_pkg::RD_RDIV_LSB +: fns_pkg::RDIV_W];
    assign div_cfg.prescaler_89 = rd_word_reg[fns_pkg::RD_PRESCALER_BIT];
    assign div_cfg.pd_polarity = ct_word_reg[fns_pkg::CT_POLARITY_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Noise and spur mode
    assign ns_mode = fns_pkg::fns_noise_e'(ns_word_reg[fns_pkg::NS_MODE_LSB +: 2]);
    assign dither_en = ns_mode == fns_pkg::NS_LOWEST_SPUR;
    assign cp_low_noise = ns_mode == fns_pkg::NS_LOWEST_NOISE;

    ////////////////////////////////////////////////////////////////////////
    // Reference and feedback pin synchronisers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ref_sync_reg <= 2'h0;
            fb_sync_reg <= 2'h0;
            ref_prev_reg <= 1'b0;
            fb_prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            ref_sync_reg <= {ref_sync_reg[0], reference_input};
            fb_sync_reg <= {fb_sync_reg[0], fb_div_in};
            ref_prev_reg <= ref_sync_reg[1];
            fb_prev_reg <= fb_sync_reg[1];
        end
    end

    assign ref_rise = ref_sync_reg[1] & ~ref_prev_reg;
    assign ref_fall = ~ref_sync_reg[1] & ref_prev_reg;
    assign ref_edge = doubler_bit ? (ref_rise | ref_fall) : ref_fall;
    assign fb_tick = fb_sync_reg[1] & ~fb_prev_reg & ~hold_counters;

    ////////////////////////////////////////////////////////////////////////
    // Reference counter
    assign r_ratio = (div_cfg.ref_div == 4'h0) ? 4'h1 : div_cfg.ref_div;
    assign r_wrap = rcnt_reg >= r_ratio - 4'h1;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rcnt_reg <= 4'h0;
            ref_tick_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (hold_counters)
            begin
                rcnt_reg <= 4'h0;
                ref_tick_reg <= 1'b0;
            end
            else
            begin
                ref_tick_reg <= ref_edge & r_wrap;
                if (ref_edge)
                    rcnt_reg <= r_wrap ? 4'h0 : rcnt_reg + 4'h1;
            end
        end
    end

    assign ref_tick = ref_tick_reg;

    ////////////////////////////////////////////////////////////////////////
    // Fast-lock timer, counted in PFD cycles
    assign fast_active = timer_reg != '0;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            timer_reg <= '0;
        else if (clk_en)
        begin
            if (pd_bit)
                timer_reg <= '0;
            else if (wr_fb && word.data[fns_pkg::FB_FAST_BIT])
                timer_reg <= timer_load_reg;
            else if (ref_tick_reg && fast_active)
                timer_reg <= timer_reg - TIMER_W'(1);
        end
    end

    assign cp_fast = fast_active;

    ////////////////////////////////////////////////////////////////////////
    // Digital lock detect
    assign lock_clear = wr_fb | hold_counters;

    fns_lock_detect u_lock_detect
    (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .clear(lock_clear),
        .precise(precision_bit),
        .ref_tick(ref_tick_reg),
        .fb_tick(fb_tick),
        .locked(locked)
    );

    assign lock_detect = locked;

    ////////////////////////////////////////////////////////////////////////
    // Monitor output multiplexer
    assign mon_sel = rd_word_reg[fns_pkg::RD_MON_LSB +: fns_pkg::MON_W];

    always_comb
    begin
        mon_level = 1'b0;
        mon_drive = 1'b1;
        unique case (fns_pkg::fns_mon_e'(mon_sel))
            fns_pkg::MON_TRISTATE: mon_drive = 1'b0;
            fns_pkg::MON_DIGITAL_LOCK: mon_level = locked;
            fns_pkg::MON_FEEDBACK_DIV: mon_level = fb_sync_reg[1];
            fns_pkg::MON_LOGIC_HIGH: mon_level = 1'b1;
            fns_pkg::MON_REFERENCE_DIV: mon_level = ref_tick_reg;
            fns_pkg::MON_ANALOG_LOCK:
            begin
                mon_level = 1'b0;
                mon_drive = ~locked;
            end
            fns_pkg::MON_FAST_SWITCH:
            begin
                mon_level = 1'b0;
                mon_drive = fast_active;
            end
            fns_pkg::MON_LOGIC_LOW: mon_level = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered monitor pin
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mon_out_reg <= 1'b0;
            mon_oe_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            mon_out_reg <= mon_level;
            mon_oe_reg <= mon_drive;
        end
    end

    assign mon_out = mon_out_reg;
    assign mon_oe = mon_oe_reg;

endmodule : fns_control_regs
`default_nettype wire

// *** verification/fns_host_model.sv ***
// Host model writing words over the three-wire link
`timescale 1ns/1ps
`default_nettype none
module fns_host_model
(
    output logic ser_clk,
    output logic ser_data,
    output logic ser_load
);
    initial
    begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_load = 1'b0;
    end
    // MSB first on rising edges, then load strobe
    task send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            ser_data = w[i];
            #62.5 ser_clk = 1'b1;
            #62.5 ser_clk = 1'b0;
        end
        ser_data = ~w[0];
        ser_load = 1'b1;
        #62.5 ser_load = 1'b0;
    endtask : send
endmodule : fns_host_model
`default_nettype wire

// *** verification/fns_regs_checker.sv ***
// Assertion checker for the synthesizer control logic
`timescale 1ns/1ps
`default_nettype none
module fns_regs_checker
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ref_tick,
    input wire logic lock_detect,
    input wire logic cp_fast,
    input wire logic cp_three_state,
    input wire logic cp_low_noise,
    input wire logic dither_en,
    input wire logic counters_reset,
    input wire logic power_down
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Ticks seen since lock or counter reset was last high
    logic [7:0] tick_cnt;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            tick_cnt <= 8'h00;
        else if (lock_detect || counters_reset)
            tick_cnt <= 8'h00;
        else if (ref_tick && tick_cnt != 8'hff)
            tick_cnt <= tick_cnt + 8'h01;
    end
    ////////////////////////////////////////////////////////////////
    property p_pd_tri; power_down |-> cp_three_state; endproperty
    a_pd_tri: assert property (p_pd_tri) else $error("pump not floated");
    property p_pd_cnt; power_down |-> counters_reset; endproperty
    a_pd_cnt: assert property (p_pd_cnt) else $error("counters not reset");
    property p_pd_lock; power_down ##1 power_down |-> !lock_detect; endproperty
    a_pd_lock: assert property (p_pd_lock) else $error("lock kept in power-down");
    property p_pd_fast; power_down ##1 power_down |-> !cp_fast; endproperty
    a_pd_fast: assert property (p_pd_fast) else $error("fast kept in power-down");
    property p_hold_tick; counters_reset ##1 counters_reset |-> !ref_tick; endproperty
    a_hold_tick: assert property (p_hold_tick) else $error("tick in reset");
    property p_tick_pulse; ref_tick |=> !ref_tick; endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
    property p_mode_excl; cp_low_noise |-> !dither_en; endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("dither in low noise");
    property p_fast_fall;
        $fell(cp_fast) |-> $past(ref_tick) || $past(ref_tick, 2) || $past(power_down);
    endproperty
    a_fast_fall: assert property (p_fast_fall) else $error("fast ended untimed");
    property p_lock_count; $rose(lock_detect) |-> tick_cnt >= 8'h18; endproperty
    a_lock_count: assert property (p_lock_count) else $error("lock too early");
endmodule : fns_regs_checker
bind fns_control_regs fns_regs_checker u_chk
(
    .core_clk(core_clk), .rst(rst), .ref_tick(ref_tick), .lock_detect(lock_detect),
    .cp_fast(cp_fast), .cp_three_state(cp_three_state), .cp_low_noise(cp_low_noise),
    .dither_en(dither_en), .counters_reset(counters_reset), .power_down(power_down)
);
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking testbench for the synthesizer control logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk, rst, clk_en, reference_input, fb_follow, ser_clk, ser_data, ser_load;
    logic cp_fast, cp_three_state, cp_low_noise, dither_en, counters_reset, power_down;
    logic ref_tick, lock_detect, mon_out, mon_oe, seen;
    logic [2:0] ref_cnt;
    logic [fns_pkg::CP_CUR_W-1:0] cp_current;
    fns_pkg::fns_div_s div_cfg;
    wire logic fb_div_in = fb_follow & ~reference_input;
    int err_count, checked, n;
    fns_host_model u_host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load));
    fns_control_regs u_dut
    (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_load(ser_load), .reference_input(reference_input),
        .fb_div_in(fb_div_in), .div_cfg(div_cfg), .cp_current(cp_current), .cp_fast(cp_fast),
        .cp_three_state(cp_three_state), .cp_low_noise(cp_low_noise), .dither_en(dither_en),
        .counters_reset(counters_reset), .power_down(power_down), .ref_tick(ref_tick),
        .lock_detect(lock_detect), .mon_out(mon_out), .mon_oe(mon_oe)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Reference pin with a 16 cycle period
    always @(posedge core_clk)
    begin
        #1;
        ref_cnt = ref_cnt + 3'h1;
        if (ref_cnt == 3'h0)
            reference_input = ~reference_input;
    end
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task end_of_test;
        $display("checks=%0d errors=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task step;
        @(posedge core_clk);
        #1;
    endtask : step
    task wr(input logic [23:0] w);
        u_host.send(w);
        repeat (10) step();
    endtask : wr
    task wait_lock(input logic lvl, input int lim);
        n = 0;
        while (lock_detect !== lvl)
        begin
            step();
            n += int'(ref_tick === 1'b1);
            lim--;
            if (lim == 0)
            begin
                err_count++;
                end_of_test();
            end
        end
    endtask : wait_lock
    task tick_rate(input logic [23:0] c, input logic [23:0] r, input int exp);
        wr(c);
        wr(r);
        n = 0;
        repeat (160)
        begin
            step();
            n += int'(ref_tick === 1'b1);
        end
        chk(32'(n), 32'(exp));
    endtask : tick_rate
    ////////////////////////////////////////////////////////////////
    task t_init;
        logic [23:0] m [3];
        logic [1:0] e [3];
        m = '{24'h000003, 24'h00000f, 24'h000007};
        e = '{2'h1, 2'h2, 2'h0};
        chk(32'({cp_fast, counters_reset, power_down, lock_detect, mon_oe}), 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(m[i]);
            chk(32'({cp_low_noise, dither_en}), 32'(e[i]));
        end
        wr(24'h000546);
        chk(32'({counters_reset, cp_current}), 32'h1a);
        wr(24'h048191);
        chk(32'({div_cfg.ref_div, div_cfg.fraction_modulus}), 32'h2000);
        chk(32'({div_cfg.prescaler_89, div_cfg.pd_polarity}), 32'h3);
        wr(24'h190014);
        chk(32'({div_cfg.int_value, div_cfg.fraction_numerator}), 32'h64005);
        chk(32'(div_cfg.fraction_modulus), 32'h64);
        wr(24'h000502);
        chk(32'(counters_reset), 32'h0);
    endtask : t_init
    task t_rate;
        tick_rate(24'h000502, 24'h004191, 10);
        tick_rate(24'h000d02, 24'h004191, 20);
        tick_rate(24'h000502, 24'h008191, 5);
        if (ref_tick === 1'b1)
            step();
        clk_en = 1'b0;
        n = 0;
        repeat (40)
        begin
            step();
            n += int'(ref_tick === 1'b1);
        end
        clk_en = 1'b1;
        chk(32'(n), 32'h0);
    endtask : t_rate
    task t_mux;
        logic [23:0] w [3];
        logic [1:0] e [3];
        w = '{24'h304191, 24'h704191, 24'h004191};
        e = '{2'h3, 2'h2, 2'h0};
        for (int i = 0; i < 3; i++)
        begin
            wr(w[i]);
            chk(32'({mon_oe, mon_oe & mon_out}), 32'(e[i]));
        end
    endtask : t_mux
    task t_lock;
        wr(24'h104191);
        fb_follow = 1'b1;
        wr(24'h190014);
        wait_lock(1'b1, 1500);
        chk(32'(n >= 23 && n <= 26), 32'h1);
        step();
        chk(32'({mon_oe, mon_out}), 32'h3);
        wr(24'h000522);
        wr(24'h190014);
        chk(32'(lock_detect), 32'h0);
        wait_lock(1'b1, 1500);
        chk(32'(n >= 39 && n <= 42), 32'h1);
    endtask : t_lock
    task t_power;
        wr(24'h000532);
        chk(32'({power_down, cp_three_state, counters_reset, lock_detect}), 32'he);
        wr(24'h194014);
        chk(32'(div_cfg.int_value), 32'h65);
        wr(24'h00052a);
        chk(32'({power_down, cp_three_state, counters_reset}), 32'h2);
        chk(32'({div_cfg.int_value, cp_current}), 32'h65a);
        wr(24'h000522);
        wait_lock(1'b1, 1500);
        fb_follow = 1'b0;
        wait_lock(1'b0, 100);
        chk(32'(n <= 2), 32'h1);
        step();
        chk(32'({mon_oe, mon_out}), 32'h2);
    endtask : t_power
    task t_fast;
        int drv;
        wr(24'h804029);
        chk(32'({div_cfg.ref_div, div_cfg.fraction_modulus}), 32'h1064);
        wr(24'h000003);
        wr(24'h000522);
        wr(24'h604191);
        fork
            u_host.send(24'h994000);
        join_none
        n = 0;
        drv = 0;
        seen = 1'b0;
        for (int i = 0; i < 600 && !(seen && cp_fast === 1'b0); i++)
        begin
            step();
            seen |= (cp_fast === 1'b1);
            n += int'(cp_fast === 1'b1 && ref_tick === 1'b1);
            drv += int'(cp_fast === 1'b1 && mon_oe !== 1'b1);
        end
        chk(32'(n), 32'd10);
        chk(32'(drv), 32'h1);
        step();
        chk(32'(mon_oe), 32'h0);
    endtask : t_fast
    initial
    begin
        rst = 1'b1;
        clk_en = 1'b1;
        reference_input = 1'b0;
        fb_follow = 1'b0;
        ref_cnt = 3'h0;
        err_count = 0;
        checked = 0;
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        step();
        t_init();
        t_rate();
        t_mux();
        t_lock();
        t_power();
        t_fast();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
